// >>> design/gqr_handler.sv
// command handler: pin query and volatile run-time settings
`timescale 1ns/1ps
// Overview of operation
// - query reply carries opcode then success code
// - level bytes 2..8, 0xee when not gpio
// - direction bytes 3..9, 0xef when not gpio
// - opcode 0x60 selects settings; byte 1 ignored
// - settings live in flops, lost on reset
// - byte 2 bit 7 loads clock divider fields
// - byte 2 bits 4:3 choose duty cycle
// - byte 2 bits 2:0 divider, 6:5 ignored
// - byte 3 bit 7 loads reference bits 2:0
// - byte 3 bits 2:1 reference level
// - byte 3 bit 0 reference source
// - byte 4 bit 7 loads 5-bit code
module gqr_handler #(
   parameter int REPORT_BYTES = gqr_pkg::REPORT_BYTES  // bytes per report
) (
   input  wire logic       clk_sys,          // 200 mhz system clock
   input  wire logic       reset,            // synchronous, active high
   input  wire logic [7:0] cmd_data,         // command byte stream
   input  wire logic       cmd_valid,        // command byte present
   output logic            cmd_ready,        // command byte taken
   output logic [7:0]      rsp_data,         // reply byte stream
   output logic            rsp_valid,        // reply byte present
   output logic            rsp_last,         // final reply byte
   input  wire logic       rsp_ready,        // host takes reply byte
   input  wire logic [3:0] pin_is_gpio,      // pins assigned to general i/o
   input  wire logic [3:0] pin_is_input,     // pin direction, 1 input
   input  wire logic [3:0] pin_level,        // raw pin levels
   output logic [1:0]      clk_out_duty,     // reference clock duty
   output logic [2:0]      clk_out_divider,  // reference clock divider
   output logic [1:0]      ref_level,        // internal reference level
   output logic            ref_source,       // 1 internal ref, 0 supply
   output logic [4:0]      converter_code,   // output converter code
   output logic            settings_applied  // pulse: settings command done
);
   localparam logic [5:0] LAST_IDX = 6'(REPORT_BYTES - 1); // final byte index

   typedef enum logic [1:0] {GQR_RECV, GQR_SEND, GQR_DROP} gqr_phase_e;

   // whole module state
   typedef struct packed {
      gqr_phase_e            phase;    // receive, send, or discard phase
      logic [5:0]            idx;      // byte index within report
      logic [7:0]            opcode;   // byte 0 of current command
      logic [7:0]            b2;       // captured byte 2
      logic [7:0]            b3;       // captured byte 3
      logic [7:0]            b4;       // captured byte 4
      logic [3:0]            sync1;    // first synchroniser stage
      logic [3:0]            sync2;    // second synchroniser stage
      logic [79:0]           snap;     // reply bytes 0..9, byte 0 lowest
      gqr_pkg::gqr_settings_s set;     // working settings
      logic                  applied;  // settings pulse
      logic                  cmd_ready; // command bytes accepted
      logic                  rsp_valid; // reply byte offered
      logic                  rsp_last;  // final reply byte offered
      logic [7:0]            rsp_data;  // reply byte on the stream
   } gqr_state_s;

   gqr_state_s st;       // registered state
   gqr_state_s next_st;  // next state

   logic [63:0]           pin_bytes;  // formatted bytes 2..9
   gqr_pkg::gqr_pin_s [3:0] pins;      // synchronised pin views

   // pin levels come from pads, so they are synchronised; the assignment and
   // direction come from logic on this clock and pass straight through
   generate
      for (genvar g = 0; g < gqr_pkg::NUM_PINS; g++) begin : g_pin
         assign pins[g] = '{is_gpio: pin_is_gpio[g], is_input: pin_is_input[g],
                            level: st.sync2[g]};
         gqr_pin_reply u_fmt (
            .pin        (pins[g]),
            .level_byte (pin_bytes[16*g +: 8]),
            .dir_byte   (pin_bytes[16*g+8 +: 8])
         );
      end
   endgenerate

   // command capture, settings update, reply sequencing
   always_comb begin
      next_st         = st;
      next_st.sync1   = pin_level;
      next_st.sync2   = st.sync1;
      next_st.applied = 1'b0;
      case (st.phase)
         GQR_RECV: begin
            // a byte counts only on a full handshake: ready is low on the
            // first edge after reset, and a byte offered then must not be lost
            if (cmd_valid && st.cmd_ready) begin
               // byte 1 is never stored: it has no effect on either command
               if (st.idx == 6'(gqr_pkg::IDX_OPCODE)) next_st.opcode = cmd_data;
               if (st.idx == 6'(gqr_pkg::IDX_CLK_CFG)) next_st.b2 = cmd_data;
               if (st.idx == 6'(gqr_pkg::IDX_REF_CFG)) next_st.b3 = cmd_data;
               if (st.idx == 6'(gqr_pkg::IDX_CODE_CFG)) next_st.b4 = cmd_data;
               next_st.idx = st.idx + 6'h01;
               if (st.idx == LAST_IDX) begin
                  // whole command in hand before any reply byte goes out
                  next_st.idx   = 6'h00;
                  next_st.phase = GQR_SEND;
                  // snapshot keeps the reply coherent while it drains
                  next_st.snap  = {pin_bytes, gqr_pkg::CODE_SUCCESS, st.opcode};
                  if (st.opcode == gqr_pkg::OPC_SETTINGS) begin
                     next_st.applied = 1'b1;
                     if (st.b2[gqr_pkg::LOAD_BIT]) begin
                        next_st.set.duty = gqr_pkg::gqr_duty_e'(
                           st.b2[gqr_pkg::DUTY_HI:gqr_pkg::DUTY_LO]);
                        next_st.set.divider = st.b2[gqr_pkg::DIV_HI:0];
                     end
                     if (st.b3[gqr_pkg::LOAD_BIT]) begin
                        next_st.set.ref_level = gqr_pkg::gqr_ref_e'(
                           st.b3[gqr_pkg::REF_LVL_HI:gqr_pkg::REF_LVL_LO]);
                        next_st.set.ref_src = st.b3[gqr_pkg::REF_SRC_BIT];
                     end
                     if (st.b4[gqr_pkg::LOAD_BIT]) begin
                        next_st.set.code = st.b4[gqr_pkg::CODE_HI:0];
                     end
                  end else if (st.opcode != gqr_pkg::OPC_PIN_QUERY) begin
                     // other opcodes belong to other handlers: no reply here
                     next_st.phase = GQR_RECV;
                  end
               end
            end
         end
         GQR_SEND: begin
            if (rsp_ready) begin
               next_st.idx = st.idx + 6'h01;
               if (st.idx == LAST_IDX) begin
                  next_st.idx   = 6'h00;
                  next_st.phase = GQR_RECV;
               end
            end
         end
         default: begin
            next_st.phase = GQR_RECV;
            next_st.idx   = 6'h00;
         end
      endcase
      // stream outputs follow the next state so they leave straight from flops
      next_st.cmd_ready = (next_st.phase == GQR_RECV);
      next_st.rsp_valid = (next_st.phase == GQR_SEND);
      next_st.rsp_last  = (next_st.phase == GQR_SEND) && (next_st.idx == LAST_IDX);
      // bytes past the pin fields carry a fixed filler
      next_st.rsp_data  = (next_st.idx <= 6'(gqr_pkg::IDX_PIN_LAST))
                          ? next_st.snap[8*next_st.idx +: 8] : gqr_pkg::FILL_BYTE;
   end

   // state register; reset restores power-up settings
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st                <= '0;
         st.phase          <= GQR_RECV;
         st.set.duty       <= gqr_pkg::gqr_duty_e'(gqr_pkg::RST_DUTY);
         st.set.divider    <= gqr_pkg::RST_DIV;
         st.set.ref_level  <= gqr_pkg::gqr_ref_e'(gqr_pkg::RST_REF_LVL);
         st.set.ref_src    <= gqr_pkg::RST_REF_SRC;
         st.set.code       <= gqr_pkg::RST_CODE;
      end else begin
         st <= next_st;
      end
   end

   // every output is a field of the state register
   assign cmd_ready        = st.cmd_ready;
   assign rsp_data         = st.rsp_data;
   assign rsp_valid        = st.rsp_valid;
   assign rsp_last         = st.rsp_last;
   assign clk_out_duty     = st.set.duty;
   assign clk_out_divider  = st.set.divider;
   assign ref_level        = st.set.ref_level;
   assign ref_source       = st.set.ref_src;
   assign converter_code   = st.set.code;
   assign settings_applied = st.applied;

   // settings command with load bit clear leaves the code alone
   a_code_hold: assert property (@(posedge clk_sys) disable iff (reset)
      (st.phase == GQR_RECV && cmd_valid && st.idx == LAST_IDX &&
       st.opcode == gqr_pkg::OPC_SETTINGS && !st.b4[7]) |=> $stable(converter_code))
      else $error("converter code changed without load bit");

   a_code_load: assert property (@(posedge clk_sys) disable iff (reset)
      (st.phase == GQR_RECV && cmd_valid && st.idx == LAST_IDX &&
       st.opcode == gqr_pkg::OPC_SETTINGS && st.b4[7])
      |=> converter_code == $past(st.b4[4:0]))
      else $error("converter code not loaded");

   a_div_load: assert property (@(posedge clk_sys) disable iff (reset)
      (st.phase == GQR_RECV && cmd_valid && st.idx == LAST_IDX &&
       st.opcode == gqr_pkg::OPC_SETTINGS && st.b2[7])
      |=> {clk_out_duty, clk_out_divider} == $past(st.b2[4:0]))
      else $error("divider fields not loaded");

   a_div_hold: assert property (@(posedge clk_sys) disable iff (reset)
      (st.phase == GQR_RECV && cmd_valid && st.idx == LAST_IDX && !st.b2[7])
      |=> $stable(clk_out_divider) && $stable(clk_out_duty))
      else $error("divider changed without load bit");

   a_ref_load: assert property (@(posedge clk_sys) disable iff (reset)
      (st.phase == GQR_RECV && cmd_valid && st.idx == LAST_IDX &&
       st.opcode == gqr_pkg::OPC_SETTINGS && st.b3[7])
      |=> {ref_level, ref_source} == $past(st.b3[2:0]))
      else $error("reference not loaded");

   a_ref_hold: assert property (@(posedge clk_sys) disable iff (reset)
      (st.phase == GQR_RECV && cmd_valid && st.idx == LAST_IDX && !st.b3[7])
      |=> $stable(ref_level) && $stable(ref_source))
      else $error("reference changed without load bit");

   // first reply byte offered
   sequence s_reply_start;
      rsp_valid && !$past(rsp_valid);
   endsequence
   // query opcode handed over as the first reply byte
   sequence s_query_head_taken;
      s_reply_start ##0 (rsp_data == gqr_pkg::OPC_PIN_QUERY && rsp_ready);
   endsequence
   a_reply_head: assert property (@(posedge clk_sys) disable iff (reset)
      s_query_head_taken |=> rsp_valid && rsp_data == gqr_pkg::CODE_SUCCESS)
      else $error("query reply status byte wrong");

   // pin 0 outside general i/o snapshots both marker bytes
   a_pin_marker: assert property (@(posedge clk_sys) disable iff (reset)
      (st.phase == GQR_RECV && cmd_valid && cmd_ready && st.idx == LAST_IDX &&
       !pin_is_gpio[0])
      |=> st.snap[23:16] == gqr_pkg::NOT_GPIO_LEVEL && st.snap[31:24] == gqr_pkg::NOT_GPIO_DIR)
      else $error("pin marker bytes wrong");

   // a reply starts only right after the final command byte was taken
   a_no_early: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(rsp_valid) |-> $past(cmd_valid && cmd_ready && st.idx == LAST_IDX))
      else $error("reply before command complete");
endmodule

// >>> design/gqr_pkg.sv
// shared constants and carrier structs for the gpio query and settings handler
package gqr_pkg;
   localparam int          REPORT_BYTES     = 64;       // bytes per report
   localparam int          BYTE_IDX_W       = 6;        // index width for 64 bytes
   localparam logic [7:0]  OPC_PIN_QUERY    = 8'h51;    // pin query opcode
   localparam logic [7:0]  OPC_SETTINGS     = 8'h60;    // volatile settings opcode
   localparam logic [7:0]  CODE_SUCCESS     = 8'h00;    // success code
   localparam logic [7:0]  NOT_GPIO_LEVEL   = 8'hee;    // level byte, pin not general i/o
   localparam logic [7:0]  NOT_GPIO_DIR     = 8'hef;    // direction byte, pin not general i/o
   localparam logic [7:0]  FILL_BYTE        = 8'h00;    // undefined reply bytes
   localparam int          IDX_OPCODE       = 0;        // reply opcode byte
   localparam int          IDX_STATUS       = 1;        // reply status byte
   localparam int          IDX_PIN_FIRST    = 2;        // first pin level byte
   localparam int          IDX_PIN_LAST     = 9;        // last pin direction byte
   localparam int          IDX_CLK_CFG      = 2;        // command byte: clock output
   localparam int          IDX_REF_CFG      = 3;        // command byte: converter ref
   localparam int          IDX_CODE_CFG     = 4;        // command byte: converter code
   localparam int          LOAD_BIT         = 7;        // load enable position
   localparam int          DUTY_HI          = 4;        // duty field msb
   localparam int          DUTY_LO          = 3;        // duty field lsb
   localparam int          DIV_HI           = 2;        // divider field msb
   localparam int          REF_LVL_HI       = 2;        // reference level msb
   localparam int          REF_LVL_LO       = 1;        // reference level lsb
   localparam int          REF_SRC_BIT      = 0;        // reference source bit
   localparam int          CODE_HI          = 4;        // converter code msb
   localparam int          NUM_PINS         = 4;        // general pins
   localparam logic [1:0]  RST_DUTY         = 2'h2;     // power-up duty (50 percent)
   localparam logic [2:0]  RST_DIV          = 3'h1;     // power-up divider selection
   localparam logic [1:0]  RST_REF_LVL      = 2'h0;     // power-up reference level, off
   localparam logic        RST_REF_SRC      = 1'b0;     // power-up source, supply rail
   localparam logic [4:0]  RST_CODE         = 5'h00;    // power-up converter code

   // duty cycle encodings
   typedef enum logic [1:0] {
      GQR_DUTY_0, GQR_DUTY_25, GQR_DUTY_50, GQR_DUTY_75
   } gqr_duty_e;

   // internal reference level encodings
   typedef enum logic [1:0] {
      GQR_REF_OFF, GQR_REF_1V024, GQR_REF_2V048, GQR_REF_4V096
   } gqr_ref_e;

   // working copy of the volatile settings
   typedef struct packed {
      gqr_duty_e  duty;       // clock output duty
      logic [2:0] divider;    // clock output divider selection
      gqr_ref_e   ref_level;  // internal reference level
      logic       ref_src;    // 1 internal reference, 0 supply rail
      logic [4:0] code;       // output converter code
   } gqr_settings_s;

   // live view of one general pin
   typedef struct packed {
      logic is_gpio;  // pin assigned to general i/o
      logic is_input; // direction, 1 input
      logic level;    // pin logic level
   } gqr_pin_s;
endpackage

// >>> design/gqr_pin_reply.sv
// formats the two reply bytes for one general pin
`timescale 1ns/1ps
module gqr_pin_reply (
   input  wire gqr_pkg::gqr_pin_s pin,         // synchronised pin view
   output logic [7:0]             level_byte,  // reply level byte
   output logic [7:0]             dir_byte     // reply direction byte
);
   // unassigned pins report fixed markers instead of live state
   always_comb begin
      if (pin.is_gpio) begin
         level_byte = {7'h00, pin.level};
         dir_byte   = {7'h00, pin.is_input};
      end else begin
         level_byte = gqr_pkg::NOT_GPIO_LEVEL;
         dir_byte   = gqr_pkg::NOT_GPIO_DIR;
      end
   end
endmodule

// >>> sim/gqr_host.sv
// host model: offers one command report and collects one reply report
`timescale 1ns/1ps
module gqr_host (
   input  wire logic       clk_sys,    // system clock
   output logic [7:0]      cmd_data,   // command byte to handler
   output logic            cmd_valid,  // command byte offered
   input  wire logic       cmd_ready,  // handler takes byte
   input  wire logic [7:0] rsp_data,   // reply byte
   input  wire logic       rsp_valid,  // reply byte offered
   input  wire logic       rsp_last,   // final reply byte
   output logic            rsp_ready   // host takes reply byte
);
   // idle host at time zero
   initial begin
      cmd_data  = 8'h00;
      cmd_valid = 1'b0;
      rsp_ready = 1'b0;
   end

   // offer 64 bytes in order, each held until the edge that takes it
   task automatic send(input logic [511:0] rpt, output logic ok);
      int n;
      ok = 1'b1;
      for (int i = 0; i < 64; i++) begin
         cmd_data  <= rpt[8*i +: 8];
         cmd_valid <= 1'b1;
         n = 0;
         do begin
            @(posedge clk_sys);
            n++;
         end while (cmd_ready !== 1'b1 && n < 200);
         if (n >= 200) ok = 1'b0;
      end
      // released data line shows the inverse of the last byte, never a stale copy
      cmd_valid <= 1'b0;
      cmd_data  <= ~cmd_data;
   endtask

   // take 64 reply bytes; slow mode stalls every other cycle
   task automatic recv(input logic slow, output logic [511:0] rpt, output logic ok);
      int i;
      int n;
      i = 0;
      n = 0;
      ok = 1'b1;
      rpt = '0;
      rsp_ready <= 1'b1;
      while (i < 64 && n < 1000) begin
         @(posedge clk_sys);
         n++;
         if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
            rpt[8*i +: 8] = rsp_data;
            if (rsp_last !== (i == 63)) ok = 1'b0;
            i++;
         end
         rsp_ready <= (i < 64) && (!slow || !rsp_ready);
      end
      if (i < 64) ok = 1'b0;
   endtask
endmodule

// >>> sim/tb_gqr_handler.sv
// self-checking bench for the gpio query and settings handler
`timescale 1ns/1ps
module tb_gqr_handler;
   logic       clk_sys = 1'b0;  // 200 mhz clock
   logic       reset   = 1'b1;  // synchronous reset
   logic [7:0] cmd_data, rsp_data;
   logic       cmd_valid, cmd_ready, rsp_valid, rsp_last, rsp_ready, ref_source;
   logic [3:0] pin_is_gpio = 4'h0, pin_is_input = 4'h0, pin_level = 4'h0;
   logic [1:0] clk_out_duty, ref_level;
   logic [2:0] clk_out_divider;
   logic [4:0] converter_code;
   logic       settings_applied;
   int         mismatches = 0, compares = 0, applied = 0;

   gqr_handler i_gqr_handler (.clk_sys(clk_sys), .reset(reset), .cmd_data(cmd_data),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_data(rsp_data),
      .rsp_valid(rsp_valid), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
      .pin_is_gpio(pin_is_gpio), .pin_is_input(pin_is_input), .pin_level(pin_level),
      .clk_out_duty(clk_out_duty), .clk_out_divider(clk_out_divider),
      .ref_level(ref_level), .ref_source(ref_source), .converter_code(converter_code),
      .settings_applied(settings_applied));
   gqr_host i_gqr_host (.clk_sys(clk_sys), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
      .rsp_last(rsp_last), .rsp_ready(rsp_ready));

   // clock and a count of settings pulses
   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (settings_applied === 1'b1) applied++;
   end

   // verdict and end of run, also reached from a hang in xfer and from the overall bound
   task automatic close_out();
      $display("counts: compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // one comparison
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // all working settings at once
   task automatic chk_set(input logic [1:0] du, input logic [2:0] dv, input logic [1:0] lv,
                          input logic sr, input logic [4:0] cd);
      chk({6'h0, clk_out_duty}, {6'h0, du});
      chk({5'h0, clk_out_divider}, {5'h0, dv});
      chk({6'h0, ref_level}, {6'h0, lv});
      chk({7'h0, ref_source}, {7'h0, sr});
      chk({3'h0, converter_code}, {3'h0, cd});
   endtask

   // full command then full reply; a hang ends the run
   task automatic xfer(input logic [511:0] c, input logic slow, output logic [511:0] r);
      logic ok1, ok2;
      i_gqr_host.send(c, ok1);
      i_gqr_host.recv(slow, r, ok2);
      if (!(ok1 && ok2)) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, {ok1, ok2}, 2'h3);
         close_out();
      end
   endtask

   // pin query with two pin patterns, fast and stalling host
   task automatic t_query();
      logic [511:0] r;
      int a0;
      for (int k = 0; k < 2; k++) begin
         pin_is_gpio  <= k ? 4'h4 : 4'hb;
         pin_is_input <= k ? 4'h9 : 4'h6;
         pin_level    <= k ? 4'h2 : 4'hd;
         repeat (4) @(posedge clk_sys);
         a0 = applied;
         xfer({{62{8'h5a}}, 8'hff, gqr_pkg::OPC_PIN_QUERY}, k[0], r);
         chk(r[7:0], 8'h51);
         chk(r[15:8], 8'h00);
         for (int p = 0; p < 4; p++) begin
            chk(r[16*p+16 +: 8], pin_is_gpio[p] ? {7'h0, pin_level[p]} : 8'hee);
            chk(r[16*p+24 +: 8], pin_is_gpio[p] ? {7'h0, pin_is_input[p]} : 8'hef);
         end
         chk(8'(applied - a0), 8'h00);
      end
      $display("test query done");
   endtask

   // every duty, level and source code with junk in ignored bits and byte 1
   task automatic t_settings();
      logic [511:0] c, r;
      for (int k = 0; k < 4; k++) begin
         c = '0;
         c[7:0]   = gqr_pkg::OPC_SETTINGS;
         c[15:8]  = 8'hff - 8'(k);
         c[23:16] = {1'b1, k[1:0], k[1:0], 3'(7 - k)};
         c[31:24] = {1'b1, 4'hf - 4'(k), k[1:0], k[0]};
         c[39:32] = {1'b1, 2'(3 - k), 5'(k * 9)};
         xfer(c, k[0], r);
         chk(r[7:0], 8'h60);
         chk(r[15:8], 8'h00);
         chk_set(k[1:0], 3'(7 - k), k[1:0], k[0], 5'(k * 9));
         chk(8'(applied), 8'(k + 1));
      end
      // load bits clear leave all; then only the reference is loaded
      xfer({{59{8'h00}}, 8'h7f, 8'h7e, 8'h7d, 8'h00, gqr_pkg::OPC_SETTINGS}, 1'b0, r);
      chk_set(2'h3, 3'h4, 2'h3, 1'b1, 5'd27);
      xfer({{59{8'h00}}, 8'h7f, 8'h82, 8'h67, 8'h00, gqr_pkg::OPC_SETTINGS}, 1'b1, r);
      chk_set(2'h3, 3'h4, 2'h1, 1'b0, 5'd27);
      $display("test settings done");
   endtask

   // unknown opcode: no reply, no change; then reset drops the settings
   task automatic t_unknown_reset();
      logic ok;
      logic seen;
      seen = 1'b0;
      i_gqr_host.send({{59{8'h00}}, 8'h9f, 8'h87, 8'h9f, 8'h00, 8'h52}, ok);
      repeat (80) begin
         @(posedge clk_sys);
         if (rsp_valid === 1'b1) seen = 1'b1;
      end
      chk({7'h0, seen}, 8'h00);
      chk({7'h0, ok}, 8'h01);
      chk(8'(applied), 8'h06);
      chk_set(2'h3, 3'h4, 2'h1, 1'b0, 5'd27);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      chk_set(gqr_pkg::RST_DUTY, gqr_pkg::RST_DIV, gqr_pkg::RST_REF_LVL,
              gqr_pkg::RST_REF_SRC, gqr_pkg::RST_CODE);
      $display("test unknown and reset done");
   endtask

   // main sequence
   initial begin
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      chk_set(gqr_pkg::RST_DUTY, gqr_pkg::RST_DIV, gqr_pkg::RST_REF_LVL,
              gqr_pkg::RST_REF_SRC, gqr_pkg::RST_CODE);
      t_query();
      t_settings();
      t_unknown_reset();
      close_out();
   end

   // overall bound on the run
   initial begin
      #250000;
      mismatches++;
      close_out();
   end
endmodule
